// file: src/iorm_map.vh
/*
 Offsets, field positions and access masks for the I/O register bank.
 Assumes the includer works on 8-bit data and 8-bit data-space addresses.
*/
`ifndef IORM_MAP_VH
`define IORM_MAP_VH

// ============================================================
// Address windows
`define IORM_IO_LAST 8'h3F
`define IORM_BIT_LAST 8'h1F
`define IORM_DATA_OFFSET 8'h20
`define IORM_EXT_FIRST 8'h60
`define IORM_EXT_LAST 8'hFF

// ============================================================
// Operation codes on the core request port
`define IORM_OP_NONE 3'h0
`define IORM_OP_PORT_READ 3'h1
`define IORM_OP_PORT_WRITE 3'h2
`define IORM_OP_MEM_READ 3'h3
`define IORM_OP_MEM_WRITE 3'h4
`define IORM_OP_BIT_SET 3'h5
`define IORM_OP_BIT_CLEAR 3'h6
`define IORM_OP_BIT_TEST 3'h7

// ============================================================
// Data-space addresses of the registers
`define IORM_PORT_B_IN 8'h23
`define IORM_PORT_B_DIR 8'h24
`define IORM_PORT_B_OUT 8'h25
`define IORM_PORT_C_IN 8'h26
`define IORM_PORT_C_DIR 8'h27
`define IORM_PORT_C_OUT 8'h28
`define IORM_PORT_D_IN 8'h29
`define IORM_PORT_D_DIR 8'h2A
`define IORM_PORT_D_OUT 8'h2B
`define IORM_TIMER0_FLAGS 8'h35
`define IORM_TIMER1_FLAGS 8'h36
`define IORM_TIMER2_FLAGS 8'h37
`define IORM_PIN_CHANGE_FLAGS 8'h3B
`define IORM_EXT_IRQ_FLAGS 8'h3C
`define IORM_EXT_IRQ_MASK 8'h3D
`define IORM_SCRATCH_ZERO 8'h3E
`define IORM_NV_CONTROL 8'h3F
`define IORM_NV_DATA 8'h40
`define IORM_NV_ADDR_LOW 8'h41
`define IORM_NV_ADDR_HIGH 8'h42
`define IORM_GLOBAL_TIMER_CTRL 8'h43
`define IORM_TIMER0_CTRL_A 8'h44
`define IORM_TIMER0_CTRL_B 8'h45
`define IORM_TIMER0_COUNT 8'h46
`define IORM_TIMER0_CMP_A 8'h47
`define IORM_TIMER0_CMP_B 8'h48
`define IORM_SCRATCH_ONE 8'h4A
`define IORM_SCRATCH_TWO 8'h4B
`define IORM_SERIAL_CTRL 8'h4C
`define IORM_SERIAL_STATUS 8'h4D
`define IORM_SERIAL_DATA 8'h4E
`define IORM_COMPARATOR_CTRL 8'h50
`define IORM_SLEEP_CTRL 8'h53
`define IORM_RESET_CAUSE 8'h54
`define IORM_CORE_CTRL 8'h55
`define IORM_SELF_PROG_CTRL 8'h57
`define IORM_STACK_LOW 8'h5D
`define IORM_STACK_HIGH 8'h5E
`define IORM_CORE_STATUS 8'h5F
`define IORM_WATCHDOG_CTRL 8'h60
`define IORM_CLOCK_DIV_CTRL 8'h61
`define IORM_POWER_GATING 8'h64
`define IORM_OSC_TRIM 8'h66
`define IORM_PIN_CHANGE_ENABLE 8'h68
`define IORM_EXT_IRQ_SENSE 8'h69
`define IORM_PIN_CHANGE_MASK0 8'h6B
`define IORM_PIN_CHANGE_MASK1 8'h6C
`define IORM_PIN_CHANGE_MASK2 8'h6D

// ============================================================
// Implemented-bit masks; zero bits are reserved, except bits 7 and 6 of IORM_MASK_SERIAL_STATUS_W, which are read-only bits
`define IORM_MASK_PORT_C 8'h7F
`define IORM_MASK_TIMER02_FLAGS 8'h07
`define IORM_MASK_TIMER1_FLAGS 8'h27
`define IORM_MASK_PIN_CHANGE 8'h07
`define IORM_MASK_EXT_IRQ 8'h03
`define IORM_MASK_NV_CONTROL 8'h3F
`define IORM_MASK_NV_ADDR_HIGH 8'h03
`define IORM_MASK_GLOBAL_TIMER 8'h83
`define IORM_MASK_TIMER0_CTRL_A 8'hF3
`define IORM_MASK_TIMER0_CTRL_B 8'hCF
`define IORM_MASK_SERIAL_STATUS 8'hC1
`define IORM_MASK_SERIAL_STATUS_W 8'h01
`define IORM_MASK_SLEEP 8'h0F
`define IORM_MASK_RESET_CAUSE 8'h0F
`define IORM_MASK_CORE_CTRL 8'h73
`define IORM_MASK_STACK_HIGH 8'h07
`define IORM_MASK_WATCHDOG 8'hFF
`define IORM_MASK_CLOCK_DIV 8'h8F
`define IORM_MASK_POWER 8'hEF
`define IORM_MASK_EXT_SENSE 8'h0F
`define IORM_MASK_PIN_MASK1 8'h7F

// ============================================================
// Flag fields
`define IORM_SERIAL_DONE_BIT 7
`define IORM_SERIAL_COLLIDE_BIT 6
`define IORM_COMPARATOR_FLAG_BIT 4
`define IORM_COMPARATOR_OUT_BIT 5
`define IORM_WATCHDOG_FLAG_BIT 7

`endif

// file: src/iorm_register_bank.v
/*
 I/O register bank and address decoder for the core's peripheral space.
 Assumes the core presents one request per cycle on op/addr/wrData and that
 peripherals pulse their event inputs for one cycle when a flag is to be set.
*/
`timescale 1ns/1ps
`include "iorm_map.vh"

// Contract
// R1 - Software never writes an I/O address marked reserved.
// R2 - Software writes zero into reserved bit positions when it writes a register.
// R3 - Single-bit set and clear act on I/O addresses 0x00 to 0x1F and on no higher address.
// R4 - In the bit-accessible range one bit can be tested so the core can skip on high or low.
// R5 - A single-bit set or clear alters only the addressed bit and clears no other flag.
// R6 - Write-one-to-clear flags clear on a written one and keep their value on a written zero.
// R7 - Port read and port write reach I/O addresses 0x00 to 0x3F.
// R8 - Load and store reach the low I/O registers at their I/O address plus 0x20.
// R9 - Extended registers 0x60 to 0xFF are reached only by load and store.
// R10 - Reserved addresses and bits read as zero and ignore writes.
module iorm_register_bank (
    input wire core_clk,
    input wire rstn,
    input wire [2:0] op,
    input wire [7:0] addr,
    input wire [2:0] bitSel,
    input wire [7:0] wrData,
    output reg [7:0] rdData,
    output reg bitTestValue,
    output reg accessHit,
    input wire [7:0] portBPins,
    input wire [6:0] portCPins,
    input wire [7:0] portDPins,
    input wire [7:0] flagSetTimer0,
    input wire [7:0] flagSetTimer1,
    input wire [7:0] flagSetTimer2,
    input wire [7:0] flagSetPinChange,
    input wire [7:0] flagSetExtIrq,
    input wire serialDoneEvent,
    input wire comparatorEvent,
    input wire comparatorLevel,
    input wire watchdogEvent,
    output wire [7:0] portBDir,
    output wire [7:0] portBOut,
    output wire [7:0] portCDir,
    output wire [7:0] portCOut,
    output wire [7:0] portDDir,
    output wire [7:0] portDOut,
    output wire [7:0] extIrqMask,
    output wire [7:0] timer0CtrlA,
    output wire [7:0] timer0CtrlB,
    output wire [7:0] coreStatus
);

    // ============================================================
    // Register file
    // Storage is one array indexed by data-space address; masks decide which bits exist.
    reg [7:0] regs_r [0:255];
    reg [7:0] mask [0:255];
    reg [7:0] w1cMask [0:255];
    reg [7:0] setIn [0:255];
    reg [7:0] dataAddr;
    reg legalRead;
    reg legalWrite;
    reg [7:0] bitMask;
    reg [7:0] wrVal;
    reg wrEn;
    reg [7:0] readRaw;
    integer k;

    // ============================================================
    // Per-address masks
    always @* begin
        for (k = 0; k < 256; k = k + 1) begin
            mask[k] = 8'h00;
            w1cMask[k] = 8'h00;
            setIn[k] = 8'h00;
        end
        mask[`IORM_PORT_B_DIR] = 8'hFF;
        mask[`IORM_PORT_B_OUT] = 8'hFF;
        mask[`IORM_PORT_C_DIR] = `IORM_MASK_PORT_C;
        mask[`IORM_PORT_C_OUT] = `IORM_MASK_PORT_C;
        mask[`IORM_PORT_D_DIR] = 8'hFF;
        mask[`IORM_PORT_D_OUT] = 8'hFF;
        mask[`IORM_TIMER0_FLAGS] = `IORM_MASK_TIMER02_FLAGS;
        mask[`IORM_TIMER1_FLAGS] = `IORM_MASK_TIMER1_FLAGS;
        mask[`IORM_TIMER2_FLAGS] = `IORM_MASK_TIMER02_FLAGS;
        mask[`IORM_PIN_CHANGE_FLAGS] = `IORM_MASK_PIN_CHANGE;
        mask[`IORM_EXT_IRQ_FLAGS] = `IORM_MASK_EXT_IRQ;
        mask[`IORM_EXT_IRQ_MASK] = `IORM_MASK_EXT_IRQ;
        mask[`IORM_SCRATCH_ZERO] = 8'hFF;
        mask[`IORM_NV_CONTROL] = `IORM_MASK_NV_CONTROL;
        mask[`IORM_NV_DATA] = 8'hFF;
        mask[`IORM_NV_ADDR_LOW] = 8'hFF;
        mask[`IORM_NV_ADDR_HIGH] = `IORM_MASK_NV_ADDR_HIGH;
        mask[`IORM_GLOBAL_TIMER_CTRL] = `IORM_MASK_GLOBAL_TIMER;
        mask[`IORM_TIMER0_CTRL_A] = `IORM_MASK_TIMER0_CTRL_A;
        mask[`IORM_TIMER0_CTRL_B] = `IORM_MASK_TIMER0_CTRL_B;
        mask[`IORM_TIMER0_COUNT] = 8'hFF;
        mask[`IORM_TIMER0_CMP_A] = 8'hFF;
        mask[`IORM_TIMER0_CMP_B] = 8'hFF;
        mask[`IORM_SCRATCH_ONE] = 8'hFF;
        mask[`IORM_SCRATCH_TWO] = 8'hFF;
        mask[`IORM_SERIAL_CTRL] = 8'hFF;
        mask[`IORM_SERIAL_STATUS] = `IORM_MASK_SERIAL_STATUS_W;
        mask[`IORM_SERIAL_DATA] = 8'hFF;
        mask[`IORM_COMPARATOR_CTRL] = 8'hDF;
        mask[`IORM_SLEEP_CTRL] = `IORM_MASK_SLEEP;
        mask[`IORM_RESET_CAUSE] = `IORM_MASK_RESET_CAUSE;
        mask[`IORM_CORE_CTRL] = `IORM_MASK_CORE_CTRL;
        mask[`IORM_SELF_PROG_CTRL] = 8'hFF;
        mask[`IORM_STACK_LOW] = 8'hFF;
        mask[`IORM_STACK_HIGH] = `IORM_MASK_STACK_HIGH;
        mask[`IORM_CORE_STATUS] = 8'hFF;
        mask[`IORM_WATCHDOG_CTRL] = `IORM_MASK_WATCHDOG;
        mask[`IORM_CLOCK_DIV_CTRL] = `IORM_MASK_CLOCK_DIV;
        mask[`IORM_POWER_GATING] = `IORM_MASK_POWER;
        mask[`IORM_OSC_TRIM] = 8'hFF;
        mask[`IORM_PIN_CHANGE_ENABLE] = `IORM_MASK_PIN_CHANGE;
        mask[`IORM_EXT_IRQ_SENSE] = `IORM_MASK_EXT_SENSE;
        mask[`IORM_PIN_CHANGE_MASK0] = 8'hFF;
        mask[`IORM_PIN_CHANGE_MASK1] = `IORM_MASK_PIN_MASK1;
        mask[`IORM_PIN_CHANGE_MASK2] = 8'hFF;
        w1cMask[`IORM_TIMER0_FLAGS] = `IORM_MASK_TIMER02_FLAGS;
        w1cMask[`IORM_TIMER1_FLAGS] = `IORM_MASK_TIMER1_FLAGS;
        w1cMask[`IORM_TIMER2_FLAGS] = `IORM_MASK_TIMER02_FLAGS;
        w1cMask[`IORM_PIN_CHANGE_FLAGS] = `IORM_MASK_PIN_CHANGE;
        w1cMask[`IORM_EXT_IRQ_FLAGS] = `IORM_MASK_EXT_IRQ;
        w1cMask[`IORM_COMPARATOR_CTRL] = 8'h10;
        w1cMask[`IORM_WATCHDOG_CTRL] = 8'h80;
        setIn[`IORM_TIMER0_FLAGS] = flagSetTimer0 & `IORM_MASK_TIMER02_FLAGS;
        setIn[`IORM_TIMER1_FLAGS] = flagSetTimer1 & `IORM_MASK_TIMER1_FLAGS;
        setIn[`IORM_TIMER2_FLAGS] = flagSetTimer2 & `IORM_MASK_TIMER02_FLAGS;
        setIn[`IORM_PIN_CHANGE_FLAGS] = flagSetPinChange & `IORM_MASK_PIN_CHANGE;
        setIn[`IORM_EXT_IRQ_FLAGS] = flagSetExtIrq & `IORM_MASK_EXT_IRQ;
        setIn[`IORM_COMPARATOR_CTRL] = {3'h0, comparatorEvent, 4'h0};
        setIn[`IORM_WATCHDOG_CTRL] = {watchdogEvent, 7'h00};
        setIn[`IORM_SERIAL_STATUS] = {serialDoneEvent, 7'h00};
    end

    // ============================================================
    // Address decode
    always @* begin
        dataAddr = addr;
        legalRead = 1'b0;
        legalWrite = 1'b0;
        bitMask = 8'h01 << bitSel;
        case (op)
            `IORM_OP_PORT_READ: begin
                dataAddr = addr + `IORM_DATA_OFFSET; // R8
                legalRead = (addr <= `IORM_IO_LAST); // R7 R9
            end
            `IORM_OP_PORT_WRITE: begin
                dataAddr = addr + `IORM_DATA_OFFSET; // R8
                legalWrite = (addr <= `IORM_IO_LAST); // R7 R9
            end
            `IORM_OP_MEM_READ: begin
                legalRead = (addr >= `IORM_DATA_OFFSET); // R9
            end
            `IORM_OP_MEM_WRITE: begin
                legalWrite = (addr >= `IORM_DATA_OFFSET); // R9
            end
            `IORM_OP_BIT_SET, `IORM_OP_BIT_CLEAR: begin
                dataAddr = addr + `IORM_DATA_OFFSET;
                legalWrite = (addr <= `IORM_BIT_LAST); // R3
            end
            `IORM_OP_BIT_TEST: begin
                dataAddr = addr + `IORM_DATA_OFFSET;
                legalRead = (addr <= `IORM_BIT_LAST); // R4
            end
            default: begin
                dataAddr = addr;
            end
        endcase
    end

    // ============================================================
    // Read path, including live pin and comparator inputs
    always @* begin
        case (dataAddr)
            `IORM_PORT_B_IN: readRaw = portBPins;
            `IORM_PORT_C_IN: readRaw = {1'b0, portCPins};
            `IORM_PORT_D_IN: readRaw = portDPins;
            `IORM_SERIAL_STATUS: readRaw = regs_r[dataAddr] & `IORM_MASK_SERIAL_STATUS;
            `IORM_COMPARATOR_CTRL: readRaw = (regs_r[dataAddr] & 8'hDF) | {2'h0, comparatorLevel, 5'h00};
            default: readRaw = regs_r[dataAddr] & mask[dataAddr]; // R10
        endcase
    end

    // ============================================================
    // Write value; a single-bit op touches only its bit and masks other flags
    always @* begin
        wrEn = legalWrite;
        wrVal = regs_r[dataAddr];
        case (op)
            `IORM_OP_BIT_SET: wrVal = (regs_r[dataAddr] & ~w1cMask[dataAddr]) | bitMask; // R5
            `IORM_OP_BIT_CLEAR: wrVal = (regs_r[dataAddr] & ~w1cMask[dataAddr]) & ~bitMask; // R5
            default: wrVal = wrData;
        endcase
    end

    // ============================================================
    // Storage update; a hardware set in the clearing cycle wins
    genvar g;
    generate
        for (g = 0; g < 256; g = g + 1) begin : gReg
            localparam [7:0] SLOT = g;
            always @(posedge core_clk) begin
                if (!rstn) begin
                    regs_r[g] <= 8'h00;
                end else if (wrEn && dataAddr == SLOT) begin
                    regs_r[g] <= ((wrVal & mask[g] & ~w1cMask[g]) // R10
                        | (regs_r[g] & w1cMask[g] & ~wrVal) // R6
                        | setIn[g]) & (mask[g] | setIn[g]);
                end else begin
                    regs_r[g] <= regs_r[g] | setIn[g];
                end
            end
        end
    endgenerate

    // ============================================================
    // Read answer registered one cycle after the request
    always @(posedge core_clk) begin
        if (!rstn) begin
            rdData <= 8'h00;
            bitTestValue <= 1'b0;
            accessHit <= 1'b0;
        end else begin
            rdData <= legalRead ? readRaw : 8'h00;
            bitTestValue <= legalRead && (op == `IORM_OP_BIT_TEST) && |(readRaw & bitMask); // R4
            accessHit <= legalRead | legalWrite;
        end
    end

    assign portBDir = regs_r[`IORM_PORT_B_DIR];
    assign portBOut = regs_r[`IORM_PORT_B_OUT];
    assign portCDir = regs_r[`IORM_PORT_C_DIR];
    assign portCOut = regs_r[`IORM_PORT_C_OUT];
    assign portDDir = regs_r[`IORM_PORT_D_DIR];
    assign portDOut = regs_r[`IORM_PORT_D_OUT];
    assign extIrqMask = regs_r[`IORM_EXT_IRQ_MASK];
    assign timer0CtrlA = regs_r[`IORM_TIMER0_CTRL_A];
    assign timer0CtrlB = regs_r[`IORM_TIMER0_CTRL_B];
    assign coreStatus = regs_r[`IORM_CORE_STATUS];

endmodule

// file: dv/iorm_core_model.sv
/*
 Core-side model issuing port, memory and bit requests.
 Assumes the bank takes a request at the edge after it is driven.
*/
`timescale 1ns/1ps
module iorm_core_model (
    input wire core_clk,
    output reg [2:0] op,
    output reg [7:0] addr,
    output reg [2:0] bitSel,
    output reg [7:0] wrData,
    input wire [7:0] rdData,
    input wire bitTestValue,
    input wire accessHit
);
    initial begin
        op = 3'h0;
        addr = 8'h00;
        bitSel = 3'h0;
        wrData = 8'h00;
    end
    // ============================================================
    // Request cycle
    // Callers send writes to mapped places only, reserved bits zero.
    task access(input [2:0] o, input [7:0] a, input [2:0] b, input [7:0] d,
                output [7:0] rd, output bt, output hit);
        begin
            @(posedge core_clk);
            op <= o;
            addr <= a;
            bitSel <= b;
            wrData <= d;
            @(posedge core_clk);
            // Idle op is none; the other lines show the inverse so stale values never look valid.
            op <= 3'h0;
            addr <= ~a;
            bitSel <= ~b;
            wrData <= ~d;
            @(negedge core_clk);
            rd = rdData;
            bt = bitTestValue;
            hit = accessHit;
        end
    endtask
endmodule

// file: dv/iorm_register_bank_sva.sv
/*
 Port-level assertions for the I/O register bank.
 Assumes one request per cycle and answers one cycle later.
*/
`timescale 1ns/1ps
`include "iorm_map.vh"
module iorm_register_bank_sva (
    input wire core_clk,
    input wire rstn,
    input wire [2:0] op,
    input wire [7:0] addr,
    input wire [2:0] bitSel,
    input wire [7:0] wrData,
    input wire [7:0] rdData,
    input wire accessHit,
    input wire bitTestValue,
    input wire [7:0] portBOut,
    input wire [7:0] coreStatus
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wire isPort = (op == `IORM_OP_PORT_READ) || (op == `IORM_OP_PORT_WRITE);
    wire isMem = (op == `IORM_OP_MEM_READ) || (op == `IORM_OP_MEM_WRITE);
    wire isBit = (op >= `IORM_OP_BIT_SET);
    sequence port_b_output_write_s;
        op == `IORM_OP_PORT_WRITE && addr == 8'h05;
    endsequence
    // ============================================================
    // Windows and mapping
    port_window_a: assert property (isPort && addr <= 8'h3F |=> accessHit)
        else $error("port access in window refused");
    port_refuse_a: assert property (isPort && addr > 8'h3F |=> !accessHit && rdData == 8'h00)
        else $error("port access above window taken");
    bit_window_a: assert property (isBit && addr > 8'h1F |=> !accessHit && $stable(coreStatus))
        else $error("bit op above bit range took effect");
    mem_low_a: assert property (isMem && addr < 8'h20 |=> !accessHit ##0 rdData == 8'h00)
        else $error("memory access below offset taken");
    ext_mem_a: assert property (isMem && addr >= 8'h60 |=> accessHit)
        else $error("extended access refused");
    port_b_output_write_a: assert property (port_b_output_write_s |=> portBOut == $past(wrData))
        else $error("port write did not reach output");
    alias_read_a: assert property (op == `IORM_OP_MEM_READ && addr == 8'h25 |=> rdData == $past(portBOut))
        else $error("data-space alias read wrong");
    bit_set_a: assert property (op == `IORM_OP_BIT_SET && addr == 8'h05
        |=> portBOut == ($past(portBOut) | (8'h01 << $past(bitSel))))
        else $error("bit set altered other bits");
    bit_clr_a: assert property (op == `IORM_OP_BIT_CLEAR && addr == 8'h05
        |=> portBOut == ($past(portBOut) & ~(8'h01 << $past(bitSel))))
        else $error("bit clear altered other bits");
    bit_test_a: assert property (op == `IORM_OP_BIT_TEST && addr == 8'h05
        |=> bitTestValue == |($past(portBOut) & (8'h01 << $past(bitSel))))
        else $error("bit test value wrong");
    rsvd_read_a: assert property (op == `IORM_OP_PORT_READ && addr <= 8'h02 |=> rdData == 8'h00)
        else $error("reserved read not zero");
endmodule
bind iorm_register_bank iorm_register_bank_sva iorm_register_bank_sva_inst (.core_clk, .rstn, .op, .addr,
    .bitSel, .wrData, .rdData, .accessHit, .bitTestValue, .portBOut, .coreStatus);

// file: dv/tb_iorm_register_bank.sv
/*
 Self-checking bench for the I/O register bank.
 Assumes the core model's request task and one-cycle answers.
*/
`timescale 1ns/1ps
module tb_iorm_register_bank;
    reg core_clk = 1'b0;
    reg rstn = 1'b0;
    wire [2:0] op;
    wire [7:0] addr;
    wire [2:0] bitSel;
    wire [7:0] wrData;
    wire [7:0] rdData;
    wire bitTestValue;
    wire accessHit;
    wire [7:0] portBOut;
    wire [7:0] coreStatus;
    wire [63:0] outBus;
    reg [7:0] portBPins = 8'h00;
    reg [6:0] portCPins = 7'h00;
    reg [7:0] portDPins = 8'h00;
    reg [7:0] flagSet = 8'h00;
    reg evt = 1'b0;
    reg comparatorLevel = 1'b0;
    reg [7:0] rd;
    reg bt;
    reg hit;
    integer n_fail = 0;
    integer checks = 0;
    integer i;
    // Data-space addresses and their expected values after one pulse on every source.
    localparam [87:0] TA = {8'h23, 8'h26, 8'h29, 8'h35, 8'h36, 8'h37, 8'h3B, 8'h3C, 8'h4D, 8'h50, 8'h60};
    localparam [87:0] TE = {8'hA5, 8'h5A, 8'h3C, 8'h07, 8'h27, 8'h07, 8'h07, 8'h03, 8'h80, 8'h30, 8'h80};
    // Registers that drive outputs, and values that keep their reserved bits zero.
    localparam [63:0] WA = {8'h24, 8'h27, 8'h28, 8'h2A, 8'h2B, 8'h3D, 8'h44, 8'h45};
    localparam [63:0] WE = {8'h5A, 8'h35, 8'h6C, 8'hC3, 8'h96, 8'h02, 8'hA1, 8'h4A};
    always #12.5 core_clk = ~core_clk;
    iorm_core_model iorm_core_model_inst (.core_clk(core_clk), .op(op), .addr(addr), .bitSel(bitSel),
        .wrData(wrData), .rdData(rdData), .bitTestValue(bitTestValue), .accessHit(accessHit));
    iorm_register_bank iorm_register_bank_inst (.core_clk(core_clk), .rstn(rstn), .op(op), .addr(addr),
        .bitSel(bitSel), .wrData(wrData), .rdData(rdData), .bitTestValue(bitTestValue), .accessHit(accessHit),
        .portBPins(portBPins), .portCPins(portCPins), .portDPins(portDPins), .flagSetTimer0(flagSet),
        .flagSetTimer1(flagSet), .flagSetTimer2(flagSet), .flagSetPinChange(flagSet), .flagSetExtIrq(flagSet),
        .serialDoneEvent(evt), .comparatorEvent(evt), .comparatorLevel(comparatorLevel), .watchdogEvent(evt),
        .portBDir(outBus[63:56]), .portBOut(portBOut), .portCDir(outBus[55:48]), .portCOut(outBus[47:40]),
        .portDDir(outBus[39:32]), .portDOut(outBus[31:24]), .extIrqMask(outBus[23:16]),
        .timer0CtrlA(outBus[15:8]), .timer0CtrlB(outBus[7:0]), .coreStatus(coreStatus));
    // ============================================================
    // Access and compare tasks
    task chk8(input [7:0] got, input [7:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task acc(input [2:0] o, input [7:0] a, input [2:0] b, input [7:0] d);
        iorm_core_model_inst.access(o, a, b, d, rd, bt, hit);
    endtask
    task rdchk(input [2:0] o, input [7:0] a, input [7:0] exp);
        begin
            acc(o, a, 3'h0, 8'h00);
            chk8(rd, exp);
        end
    endtask
    task wrap_up;
        begin
            $display("checks=%0d n_fail=%0d", checks, n_fail);
            if (n_fail == 0 && checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        #200000;
        n_fail = n_fail + 1;
        wrap_up;
    end
    // ============================================================
    // Scenarios
    initial begin
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        acc(3'h2, 8'h05, 3'h0, 8'hAA);
        chk8({7'h00, hit}, 8'h01);
        rdchk(3'h3, 8'h25, 8'hAA);
        acc(3'h4, 8'h5F, 3'h0, 8'h81);
        rdchk(3'h1, 8'h3F, 8'h81);
        acc(3'h5, 8'h05, 3'h0, 8'h00);
        chk8(portBOut, 8'hAB);
        acc(3'h6, 8'h05, 3'h7, 8'h00);
        chk8(portBOut, 8'h2B);
        acc(3'h7, 8'h05, 3'h5, 8'h00);
        chk8({7'h00, bt}, 8'h01);
        acc(3'h7, 8'h05, 3'h4, 8'h00);
        chk8({7'h00, bt}, 8'h00);
        acc(3'h5, 8'h3F, 3'h1, 8'h00);
        chk8({coreStatus[7:1], hit}, 8'h80);
        acc(3'h1, 8'h40, 3'h0, 8'h00);
        chk8({rd[7:1], rd[0] | hit}, 8'h00);
        acc(3'h3, 8'h05, 3'h0, 8'h00);
        chk8({7'h00, hit}, 8'h00);
        acc(3'h4, 8'h66, 3'h0, 8'h5C);
        rdchk(3'h3, 8'h66, 8'h5C);
        rdchk(3'h1, 8'h02, 8'h00);
        @(posedge core_clk);
        portBPins <= 8'hA5;
        portCPins <= 7'h5A;
        portDPins <= 8'h3C;
        comparatorLevel <= 1'b1;
        flagSet <= 8'hFF;
        evt <= 1'b1;
        @(posedge core_clk);
        flagSet <= 8'h00;
        evt <= 1'b0;
        for (i = 10; i >= 0; i = i - 1)
            rdchk(3'h3, TA[8*i +: 8], TE[8*i +: 8]);
        acc(3'h2, 8'h15, 3'h0, 8'h02);
        rdchk(3'h1, 8'h15, 8'h05);
        acc(3'h2, 8'h1C, 3'h0, 8'h00);
        rdchk(3'h1, 8'h1C, 8'h03);
        acc(3'h6, 8'h15, 3'h0, 8'h00);
        acc(3'h1, 8'h15, 3'h0, 8'h00);
        chk8(rd, 8'h05);
        acc(3'h5, 8'h1C, 3'h0, 8'h00);
        rdchk(3'h1, 8'h1C, 8'h02);
        acc(3'h4, 8'h60, 3'h0, 8'h80);
        rdchk(3'h3, 8'h60, 8'h00);
        acc(3'h4, 8'h50, 3'h0, 8'h10);
        rdchk(3'h3, 8'h50, 8'h20);
        for (i = 7; i >= 0; i = i - 1)
            acc(3'h4, WA[8*i +: 8], 3'h0, WE[8*i +: 8]);
        for (i = 7; i >= 0; i = i - 1)
            chk8(outBus[8*i +: 8], WE[8*i +: 8]);
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        rdchk(3'h3, 8'h25, 8'h00);
        chk8(outBus[63:56], 8'h00);
        chk8(coreStatus, 8'h00);
        wrap_up;
    end
endmodule
